// *** include/tbdac_pkg.sv ***
// Constants and types for the tuner bias DAC mode and turbo control block
package tbdac_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int WAKE_TIME_US = 250;
  localparam int WAKE_CYCLES = (WAKE_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int BASE_CYC_PER_CODE = 8;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_POWER = 5'h00;
  localparam logic [4:0] ADDR_BOOST = 5'h01;
  localparam logic [4:0] ADDR_ENABLE = 5'h02;
  localparam logic [4:0] ADDR_SCALE = 5'h04;
  localparam logic [4:0] ADDR_RANGE = 5'h05;
  localparam logic [4:0] ADDR_CODE0 = 5'h06;
  localparam logic [4:0] ADDR_STATUS = 5'h0f;
  localparam logic [4:0] ADDR_TRIGGER = 5'h1c;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CFG_STEP_BIT = 0;
  localparam int CFG_TURBO_BIT = 1;
  localparam int SCALE_FALL_LSB = 3;
  localparam int AUTO_TRIG_BIT = 6;
  localparam logic [3:0] BOOST_RST = 4'hd;
  localparam logic [3:0] ENABLE_RST = 4'h0;
  localparam logic [7:0] RANGE_RST = 8'h00;
  localparam logic [2:0] SCALE_RST = 3'h3;
  localparam logic AUTO_TRIG_RST = 1'b0;

  // ---------------------------------------------------------------
  // Power state codes and turbo deltas
  // ---------------------------------------------------------------
  localparam logic [1:0] PS_ACTIVE = 2'h0;
  localparam logic [1:0] PS_STARTUP = 2'h1;
  localparam logic [1:0] PS_LOWPWR = 2'h2;
  localparam logic [6:0] DELTA_189 = 7'h15;
  localparam logic [6:0] DELTA_220 = 7'h12;
  localparam logic [6:0] CODE_MAX = 7'h7f;

  // ---------------------------------------------------------------
  // Serial frame
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_LAST_BIT = 4'hc;
  localparam logic [3:0] DATA_LAST_BIT = 4'h8;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_READ = 3'h3;

  typedef enum {TB_SHUTDOWN, TB_STARTUP, TB_ACTIVE, TB_LOWPWR} tbdac_mode_t;
  typedef enum {LK_IDLE, LK_CMD, LK_WDATA, LK_PARK, LK_RDATA, LK_END} tbdac_link_t;

endpackage

// *** verilog/tbdac_ctrl.sv ***
// Power modes, boost control, channel turbo and serial slave port
`timescale 1ns/1ps
module tbdac_ctrl #(
  parameter int WAKE_CYC = tbdac_pkg::WAKE_CYCLES,
  parameter int BASE_CYC = tbdac_pkg::BASE_CYC_PER_CODE,
  parameter logic [3:0] SLAVE_ID = 4'h7
) (
  // Core clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Serial port
  input wire logic sclk,
  input wire logic sdata_in,
  output logic sdata_out,
  output logic sdata_oe_n,
  // Supply and analog sense pins
  input wire logic io_supply,
  input wire logic rail_below,
  input wire logic diversity_pin,
  // Boost control
  output logic boost_switch_en,
  output logic [3:0] boost_level,
  // Channel outputs
  output logic [3:0][6:0] dac_code,
  output logic [3:0] dac_range_28v,
  output logic [3:0] channel_hiz,
  output logic [3:0] channel_overdrive
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [6:0] od_code(input logic [6:0] tgt, input logic up,
                                         input logic wide);
    logic [6:0] delta;
    logic [7:0] sum;
    delta = wide ? tbdac_pkg::DELTA_220 : tbdac_pkg::DELTA_189;
    sum = {1'b0, tgt} + {1'b0, delta};
    if (up) begin
      od_code = sum[7] ? tbdac_pkg::CODE_MAX : sum[6:0];
    end else begin
      od_code = (tgt < delta) ? 7'h00 : 7'(tgt - delta);
    end
  endfunction

  function automatic logic [19:0] od_hold(input logic [6:0] mag, input logic [2:0] scale);
    logic [23:0] base;
    logic [23:0] prod;
    base = 24'(mag) * 24'(BASE_CYC);
    prod = (base * (24'h000008 + 24'(scale))) >> 3;
    od_hold = prod[19:0];
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic io_s1, io_s2, rail_s1, rail_s2, div_s1, div_s2, div_s3;
  logic wt_s1, wt_s2, wt_s3, rt_s1, rt_s2, rt_s3;
  logic wr_tog, rd_tog;
  logic [4:0] wr_addr, link_addr;
  logic [7:0] wr_data;

  always_ff @(posedge mclk) begin
    io_s1 <= io_supply;
    io_s2 <= io_s1;
    rail_s1 <= rail_below;
    rail_s2 <= rail_s1;
    div_s1 <= diversity_pin;
    div_s2 <= div_s1;
    div_s3 <= div_s2;
    wt_s1 <= wr_tog;
    wt_s2 <= wt_s1;
    wt_s3 <= wt_s2;
    rt_s1 <= rd_tog;
    rt_s2 <= rt_s1;
    rt_s3 <= rt_s2;
  end

  // ---------------------------------------------------------------
  // Power mode machine
  // ---------------------------------------------------------------
  tbdac_pkg::tbdac_mode_t mode;
  logic [19:0] wake_cnt;
  logic wr_stb, rd_stb, regs_clear, live_mode, ps_wr;
  assign wr_stb = (wt_s2 ^ wt_s3) && live_mode;
  assign rd_stb = rt_s2 ^ rt_s3;
  assign live_mode = (mode == tbdac_pkg::TB_ACTIVE) || (mode == tbdac_pkg::TB_LOWPWR);
  assign regs_clear = (mode == tbdac_pkg::TB_SHUTDOWN) || (mode == tbdac_pkg::TB_STARTUP);
  assign ps_wr = wr_stb && (wr_addr == tbdac_pkg::ADDR_POWER);

  always_ff @(posedge mclk) begin
    if (srst || !io_s2) begin
      mode <= tbdac_pkg::TB_SHUTDOWN;
      wake_cnt <= 20'h00000;
    end else begin
      case (mode)
        tbdac_pkg::TB_SHUTDOWN: begin
          mode <= tbdac_pkg::TB_STARTUP;
          wake_cnt <= 20'h00000;
        end
        tbdac_pkg::TB_STARTUP: begin
          wake_cnt <= wake_cnt + 20'h00001;
          if (wake_cnt >= 20'(WAKE_CYC - 2)) begin
            mode <= tbdac_pkg::TB_ACTIVE;
          end
        end
        tbdac_pkg::TB_ACTIVE: begin
          if (ps_wr && wr_data[1:0] == tbdac_pkg::PS_STARTUP) begin
            mode <= tbdac_pkg::TB_STARTUP;
            wake_cnt <= 20'h00000;
          end else if (ps_wr && wr_data[1:0] == tbdac_pkg::PS_LOWPWR) begin
            mode <= tbdac_pkg::TB_LOWPWR;
          end
        end
        tbdac_pkg::TB_LOWPWR: begin
          if (ps_wr && wr_data[1:0] == tbdac_pkg::PS_STARTUP) begin
            mode <= tbdac_pkg::TB_STARTUP;
            wake_cnt <= 20'h00000;
          end else if (ps_wr && wr_data[1:0] == tbdac_pkg::PS_ACTIVE) begin
            mode <= tbdac_pkg::TB_ACTIVE;
          end
        end
        default: mode <= tbdac_pkg::TB_SHUTDOWN;
      endcase
    end
  end

  logic [1:0] ps_code;
  always_comb begin
    case (mode)
      tbdac_pkg::TB_ACTIVE: ps_code = tbdac_pkg::PS_ACTIVE;
      tbdac_pkg::TB_LOWPWR: ps_code = tbdac_pkg::PS_LOWPWR;
      default: ps_code = tbdac_pkg::PS_STARTUP;
    endcase
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [3:0] chan_en;
  logic [7:0] range_cfg;
  logic [2:0] rise_scale, fall_scale;
  logic auto_trig;

  always_ff @(posedge mclk) begin
    if (srst || regs_clear) begin
      boost_level <= tbdac_pkg::BOOST_RST;
      chan_en <= tbdac_pkg::ENABLE_RST;
      range_cfg <= tbdac_pkg::RANGE_RST;
      rise_scale <= tbdac_pkg::SCALE_RST;
      fall_scale <= tbdac_pkg::SCALE_RST;
      auto_trig <= tbdac_pkg::AUTO_TRIG_RST;
    end else if (wr_stb) begin
      case (wr_addr)
        tbdac_pkg::ADDR_BOOST: boost_level <= wr_data[3:0];
        tbdac_pkg::ADDR_ENABLE: chan_en <= wr_data[3:0];
        tbdac_pkg::ADDR_RANGE: range_cfg <= wr_data;
        tbdac_pkg::ADDR_SCALE: begin
          rise_scale <= wr_data[2:0];
          fall_scale <= wr_data[tbdac_pkg::SCALE_FALL_LSB +: 3];
          auto_trig <= wr_data[tbdac_pkg::AUTO_TRIG_BIT];
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Boost regulation and output gating
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      boost_switch_en <= 1'b0;
      channel_hiz <= 4'hf;
    end else begin
      boost_switch_en <= rail_s2 && ((mode == tbdac_pkg::TB_STARTUP) ||
                         (mode == tbdac_pkg::TB_ACTIVE));
      channel_hiz <= (mode == tbdac_pkg::TB_ACTIVE) ? ~chan_en : 4'hf;
    end
  end

  // ---------------------------------------------------------------
  // Channel update and turbo
  // ---------------------------------------------------------------
  logic [3:0][6:0] target;
  logic [3:0] pending, rising, from_zero;
  logic [3:0][19:0] od_cnt;
  logic trig;
  assign trig = (wr_stb && wr_addr == tbdac_pkg::ADDR_TRIGGER) || (div_s2 ^ div_s3);

  always_ff @(posedge mclk) begin
    if (srst || regs_clear) begin
      target <= '0;
      dac_code <= '0;
      pending <= 4'h0;
      rising <= 4'h0;
      from_zero <= 4'h0;
      channel_overdrive <= 4'h0;
      od_cnt <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (mode == tbdac_pkg::TB_LOWPWR) begin
          from_zero[i] <= 1'b1;
        end
        if (wr_stb && wr_addr == 5'(tbdac_pkg::ADDR_CODE0 + 5'(i))) begin
          target[i] <= wr_data[6:0];
          if (range_cfg[2*i + tbdac_pkg::CFG_TURBO_BIT] &&
              wr_data[6:0] != (from_zero[i] ? 7'h00 : dac_code[i])) begin
            pending[i] <= 1'b1;
            rising[i] <= wr_data[6:0] > (from_zero[i] ? 7'h00 : dac_code[i]);
          end else begin
            dac_code[i] <= wr_data[6:0];
            channel_overdrive[i] <= 1'b0;
            pending[i] <= 1'b0;
          end
        end else if (!(chan_en[i] && mode == tbdac_pkg::TB_ACTIVE)) begin
          if (channel_overdrive[i]) begin
            dac_code[i] <= target[i];
            channel_overdrive[i] <= 1'b0;
          end
        end else if (pending[i] && (trig || auto_trig)) begin
          pending[i] <= 1'b0;
          from_zero[i] <= 1'b0;
          if (channel_overdrive[i]) begin
            dac_code[i] <= target[i];
            channel_overdrive[i] <= 1'b0;
          end else begin
            dac_code[i] <= od_code(target[i], rising[i],
                                   range_cfg[2*i + tbdac_pkg::CFG_STEP_BIT]);
            channel_overdrive[i] <= 1'b1;
            od_cnt[i] <= rising[i] ?
              od_hold(7'(target[i] - (from_zero[i] ? 7'h00 : dac_code[i])), rise_scale) :
              od_hold(7'(dac_code[i] - target[i]), fall_scale);
          end
        end else if (channel_overdrive[i]) begin
          if (od_cnt[i] == 20'h00000) begin
            dac_code[i] <= target[i];
            channel_overdrive[i] <= 1'b0;
          end else begin
            od_cnt[i] <= od_cnt[i] - 20'h00001;
          end
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      dac_range_28v[i] = range_cfg[2*i + tbdac_pkg::CFG_STEP_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Read data and link reset
  // ---------------------------------------------------------------
  logic [7:0] rd_word;
  logic iface_off;

  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_word <= 8'h00;
      iface_off <= 1'b1;
    end else begin
      iface_off <= (mode == tbdac_pkg::TB_SHUTDOWN);
      if (rd_stb) begin
        case (link_addr)
          tbdac_pkg::ADDR_POWER: rd_word <= {6'h00, ps_code};
          tbdac_pkg::ADDR_BOOST: rd_word <= {4'h0, boost_level};
          tbdac_pkg::ADDR_ENABLE: rd_word <= {4'h0, chan_en};
          tbdac_pkg::ADDR_SCALE: rd_word <= {1'b0, auto_trig, fall_scale, rise_scale};
          tbdac_pkg::ADDR_RANGE: rd_word <= range_cfg;
          tbdac_pkg::ADDR_STATUS: rd_word <= {channel_overdrive, pending};
          tbdac_pkg::ADDR_CODE0: rd_word <= {1'b0, target[0]};
          5'h07: rd_word <= {1'b0, target[1]};
          5'h08: rd_word <= {1'b0, target[2]};
          5'h09: rd_word <= {1'b0, target[3]};
          default: rd_word <= 8'h00;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Serial link slave
  // ---------------------------------------------------------------
  logic ir_s1, ir_s2;
  tbdac_pkg::tbdac_link_t lstate;
  logic [11:0] sh;
  logic [3:0] bcnt;
  logic [8:0] osh;
  logic [12:0] cmd_word;
  logic [8:0] data_word;
  assign cmd_word = {sh, sdata_in};
  assign data_word = {sh[7:0], sdata_in};

  always_ff @(posedge sclk) begin
    ir_s1 <= iface_off;
    ir_s2 <= ir_s1;
  end

  always_ff @(posedge sclk) begin
    if (ir_s2) begin
      lstate <= tbdac_pkg::LK_IDLE;
      sh <= 12'h000;
      bcnt <= 4'h0;
      osh <= 9'h000;
      wr_tog <= 1'b0;
      rd_tog <= 1'b0;
      wr_addr <= 5'h00;
      link_addr <= 5'h00;
      wr_data <= 8'h00;
      sdata_out <= 1'b0;
      sdata_oe_n <= 1'b1;
    end else begin
      case (lstate)
        tbdac_pkg::LK_IDLE: begin
          bcnt <= 4'h0;
          if (sdata_in) begin
            lstate <= tbdac_pkg::LK_CMD;
          end
        end
        tbdac_pkg::LK_CMD: begin
          sh <= {sh[10:0], sdata_in};
          bcnt <= bcnt + 4'h1;
          if (bcnt == tbdac_pkg::CMD_LAST_BIT) begin
            bcnt <= 4'h0;
            lstate <= tbdac_pkg::LK_IDLE;
            if (^cmd_word && cmd_word[12:9] == SLAVE_ID) begin
              link_addr <= cmd_word[5:1];
              if (cmd_word[8:6] == tbdac_pkg::CMD_WRITE) begin
                lstate <= tbdac_pkg::LK_WDATA;
              end else if (cmd_word[8:6] == tbdac_pkg::CMD_READ) begin
                rd_tog <= ~rd_tog;
                lstate <= tbdac_pkg::LK_PARK;
              end
            end
          end
        end
        tbdac_pkg::LK_WDATA: begin
          sh <= {sh[10:0], sdata_in};
          bcnt <= bcnt + 4'h1;
          if (bcnt == tbdac_pkg::DATA_LAST_BIT) begin
            if (^data_word) begin
              wr_data <= data_word[8:1];
              wr_addr <= link_addr;
              wr_tog <= ~wr_tog;
            end
            lstate <= tbdac_pkg::LK_END;
          end
        end
        tbdac_pkg::LK_PARK: begin
          sdata_out <= rd_word[7];
          sdata_oe_n <= 1'b0;
          osh <= {rd_word[6:0], ~^rd_word, 1'b0};
          bcnt <= 4'h0;
          lstate <= tbdac_pkg::LK_RDATA;
        end
        tbdac_pkg::LK_RDATA: begin
          sdata_out <= osh[8];
          osh <= {osh[7:0], 1'b0};
          bcnt <= bcnt + 4'h1;
          if (bcnt == tbdac_pkg::DATA_LAST_BIT) begin
            sdata_out <= 1'b0;
            lstate <= tbdac_pkg::LK_END;
          end
        end
        tbdac_pkg::LK_END: begin
          sdata_out <= 1'b0;
          sdata_oe_n <= 1'b1;
          lstate <= tbdac_pkg::LK_IDLE;
        end
        default: lstate <= tbdac_pkg::LK_IDLE;
      endcase
    end
  end

endmodule

// *** bench/tbdac_monitor.sv ***
// Port checks for the mode and turbo control block
`timescale 1ns/1ps
module tbdac_monitor #(
  parameter int WAKE_CYC = 20,
  parameter int BASE_CYC = 2,
  parameter logic [3:0] SLAVE_ID = 4'h7
) (
  // Clocks, reset and link
  input wire logic mclk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic sdata_in,
  input wire logic sdata_out,
  input wire logic sdata_oe_n,
  // Pins
  input wire logic io_supply,
  input wire logic rail_below,
  input wire logic diversity_pin,
  // Outputs
  input wire logic boost_switch_en,
  input wire logic [3:0] boost_level,
  input wire logic [3:0][6:0] dac_code,
  input wire logic [3:0] dac_range_28v,
  input wire logic [3:0] channel_hiz,
  input wire logic [3:0] channel_overdrive
);
  localparam int OD_MAX = 127 * BASE_CYC * 15 / 8 + 1;
  int od_cnt;
  // Length of the overdrive on channel 0
  always_ff @(posedge mclk) begin
    if (srst || !channel_overdrive[0]) begin
      od_cnt <= 0;
    end else begin
      od_cnt <= od_cnt + 1;
    end
  end
  shut_outputs_a: assert property (@(posedge mclk) disable iff (srst)
    (!io_supply) [*5] |=> channel_hiz == 4'hf && !boost_switch_en && channel_overdrive == 4'h0)
    else $error("outputs live when off");
  reg_defaults_a: assert property (@(posedge mclk) disable iff (srst)
    (!io_supply) [*5] |=> boost_level == tbdac_pkg::BOOST_RST && dac_code == '0)
    else $error("registers kept when off");
  boost_gate_a: assert property (@(posedge mclk) disable iff (srst)
    (!rail_below) [*4] |-> !boost_switch_en)
    else $error("boost on above level");
  od_hold_a: assert property (@(posedge mclk) disable iff (srst)
    channel_overdrive[0] && $past(channel_overdrive[0]) |-> $stable(dac_code[0]))
    else $error("overdrive code moved");
  od_bound_a: assert property (@(posedge mclk) disable iff (srst)
    od_cnt <= OD_MAX)
    else $error("overdrive too long");
  od_enabled_a: assert property (@(posedge mclk) disable iff (srst)
    (channel_overdrive & channel_hiz) == 4'h0)
    else $error("overdrive on idle channel");
  read_turn_a: assert property (@(posedge sclk) disable iff (srst)
    $fell(sdata_oe_n) |-> (!sdata_oe_n) [*8] ##1 !sdata_oe_n ##1 !sdata_oe_n ##1 sdata_oe_n)
    else $error("read drive window wrong");
  link_quiet_a: assert property (@(posedge sclk) disable iff (srst)
    (!io_supply) [*4] |=> sdata_oe_n)
    else $error("data pin driven when off");
endmodule
bind tbdac_ctrl tbdac_monitor #(.WAKE_CYC(WAKE_CYC), .BASE_CYC(BASE_CYC), .SLAVE_ID(SLAVE_ID))
  u_mon (.mclk, .srst, .sclk, .sdata_in, .sdata_out, .sdata_oe_n, .io_supply, .rail_below,
  .diversity_pin, .boost_switch_en, .boost_level, .dac_code, .dac_range_28v, .channel_hiz,
  .channel_overdrive);

// *** bench/tbdac_host.sv ***
// Serial link master model
`timescale 1ns/1ps
module tbdac_host (
  // Link pins
  output logic sclk,
  output logic sdata_in,
  input wire logic sdata_out,
  input wire logic sdata_oe_n
);
  logic drv;
  logic hbit;
  // Line: slave, master or pull-down
  assign sdata_in = !sdata_oe_n ? sdata_out : (drv & hbit);
  initial begin
    sclk = 1'b0;
    drv = 1'b1;
    hbit = 1'b0;
  end
  // One link period; s is the line before the rising edge
  task automatic bit1(input logic b, output logic s);
    hbit = b;
    #80;
    s = sdata_in;
    sclk = 1'b1;
    #80;
    sclk = 1'b0;
  endtask
  task automatic idle(input int n);
    logic s;
    repeat (n) bit1(1'b0, s);
  endtask
  // Whole frame; a read returns data and parity
  task automatic frame(input logic [3:0] sa, input logic rd, input logic [4:0] a,
      input logic [7:0] d, input int n, output logic [8:0] q);
    logic [11:0] h;
    logic s;
    h = {sa, rd ? tbdac_pkg::CMD_READ : tbdac_pkg::CMD_WRITE, a};
    q = 9'h000;
    #3;
    bit1(1'b1, s);
    for (int i = 11; i >= 0; i--) bit1(h[i], s);
    bit1(~^h, s);
    if (rd) begin
      drv = 1'b0;
      for (int i = 0; i < 11; i++) begin
        bit1(1'b0, s);
        if (i > 0 && i < 10) q = {q[7:0], s};
      end
      drv = 1'b1;
    end else begin
      for (int i = 7; i >= 0; i--) bit1(d[i], s);
      bit1(~^d, s);
      bit1(1'b0, s);
    end
    idle(n);
  endtask
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the mode and turbo control block
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
  $display("BAD %0t got %0h exp %0h", $time, (a), (b)); end end
module tb;
  localparam int WAKE = 20;
  localparam int BASE = 2;
  localparam logic [3:0] SID = 4'h7;
  logic mclk, srst, io_supply, rail_below, diversity_pin, sclk, sdata_in;
  logic sdata_out, sdata_oe_n, boost_switch_en;
  logic [3:0] boost_level, dac_range_28v, channel_hiz, channel_overdrive;
  logic [3:0][6:0] dac_code;
  logic [6:0] od_val;
  logic [8:0] q;
  int failures, n_tests, seed, od_len, old0, t, d, s, hold, od;
  int mreg [32];
  tbdac_ctrl #(.WAKE_CYC(WAKE), .BASE_CYC(BASE), .SLAVE_ID(SID)) u_dut (.mclk, .srst, .sclk,
    .sdata_in, .sdata_out, .sdata_oe_n, .io_supply, .rail_below, .diversity_pin,
    .boost_switch_en, .boost_level, .dac_code, .dac_range_28v, .channel_hiz,
    .channel_overdrive);
  tbdac_host u_host (.sclk, .sdata_in, .sdata_out, .sdata_oe_n);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (channel_overdrive[0] === 1'b1) begin
      od_len++;
      od_val = dac_code[0];
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic boot;
    foreach (mreg[i]) mreg[i] = 0;
    mreg[1] = 13;
    mreg[4] = 8'h1b;
    tick(WAKE + 10);
    u_host.idle(4);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    u_host.frame(SID, 1'b0, a, v, 4, q);
    mreg[a] = v;
    tick(8);
  endtask
  task automatic rd_all;
    for (int a = 0; a < 6; a++) begin
      u_host.frame(SID, 1'b1, 5'(a), 8'h00, 4, q);
      `CHK(q[8:1], 8'(mreg[a]))
      `CHK(^q, 1'b1)
    end
  endtask
  task automatic wrap_up;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #800000;
    failures++;
    wrap_up();
  end
  initial begin
    {srst, io_supply, rail_below, diversity_pin} = 4'h8;
    {failures, n_tests, od_len} = '0;
    seed = 32'he24b;
    tick(20);
    srst = 1'b0;
    // Link clocked while the IO supply is low so its reset lands
    u_host.idle(5);
    tick(1);
    io_supply = 1'b1;
    boot();
    `CHK(channel_hiz, 4'hf)
    rd_all();
    u_host.frame(~SID, 1'b0, 5'h01, 8'h05, 16, q);
    rd_all();
    d = $random(seed) & 15;
    wr(5'h01, 8'(d));
    `CHK(boost_level, 4'(d))
    rail_below = 1'b1;
    tick(6);
    `CHK(boost_switch_en, 1'b1)
    rail_below = 1'b0;
    tick(6);
    `CHK(boost_switch_en, 1'b0)
    d = $random(seed) & 8'h55;
    wr(5'h05, 8'(d));
    `CHK(dac_range_28v, {d[6], d[4], d[2], d[0]})
    wr(5'h02, 8'h0f);
    for (int i = 3; i >= 0; i--) begin
      old0 = $random(seed) & 63;
      wr(5'(6 + i), 8'(old0));
      `CHK(dac_code[i], 7'(old0))
    end
    wr(5'h02, 8'h05);
    `CHK(channel_hiz, 4'ha)
    wr(5'h01, 8'h0f);
    for (int k = 0; k < 16; k++) begin
      s = k >> 1;
      wr(5'h04, 8'(((k % 3 == 2) ? 64 : 0) | (s << 3) | s));
      wr(5'h05, 8'(2 | (s & 1)));
      t = (k % 2) ? ((k & 4) ? 60 - k : k) : ((k & 4) ? 70 + k : 127 - k);
      d = (s & 1) ? 18 : 21;
      od = (t > old0) ? ((t + d > 127) ? 127 : t + d) : ((t < d) ? 0 : t - d);
      hold = (t > old0 ? t - old0 : old0 - t) * BASE * (8 + s) / 8 + 1;
      od_len = 0;
      wr(5'h06, 8'(t));
      if (k % 3 != 2) begin
        `CHK(dac_code[0], 7'(old0))
      end
      if (k % 3 == 0) wr(5'h1c, 8'h00);
      if (k % 3 == 1) diversity_pin = ~diversity_pin;
      tick(400);
      `CHK(od_len, hold)
      `CHK(od_val, 7'(od))
      `CHK(dac_code[0], 7'(t))
      old0 = t;
    end
    wr(5'h00, 8'h02);
    rail_below = 1'b1;
    tick(WAKE + 10);
    `CHK(channel_hiz, 4'hf)
    `CHK(boost_switch_en, 1'b0)
    rd_all();
    wr(5'h00, 8'h00);
    `CHK(channel_hiz, 4'ha)
    `CHK(boost_switch_en, 1'b1)
    wr(5'h00, 8'h01);
    boot();
    `CHK(channel_hiz, 4'hf)
    rd_all();
    wr(5'h01, 8'h03);
    wr(5'h06, 8'h2a);
    io_supply = 1'b0;
    tick(10);
    `CHK(boost_level, 4'hd)
    `CHK(dac_code, 28'h0)
    `CHK(boost_switch_en, 1'b0)
    u_host.idle(5);
    tick(1);
    io_supply = 1'b1;
    boot();
    rd_all();
    wrap_up();
  end
endmodule
